// File: client_framer_pkg.sv
// Shared constants and types for the request client framer
package client_framer_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [15:0] RESP_TIMEOUT_MS = 16'h03E8;
	// Transaction table
	localparam int MAX_TRANS = 16;
	localparam int SLOT_W = 4;
	localparam int SEQ_W = 12;
	// Header layout and field values
	localparam logic [15:0] PROTO_ID = 16'h0000;
	localparam logic [7:0] UNIT_NONSIG = 8'hFF;
	localparam logic [7:0] EXC_OFFSET = 8'h80;
	localparam logic [15:0] LEN_FIXED = 16'h0002;
	localparam logic [2:0] HDR_TID_HI = 3'h0;
	localparam logic [2:0] HDR_TID_LO = 3'h1;
	localparam logic [2:0] HDR_PID_HI = 3'h2;
	localparam logic [2:0] HDR_PID_LO = 3'h3;
	localparam logic [2:0] HDR_LEN_HI = 3'h4;
	localparam logic [2:0] HDR_LEN_LO = 3'h5;
	localparam logic [2:0] HDR_UNIT = 3'h6;
	localparam logic [2:0] HDR_FUNC = 3'h7;
	localparam logic [15:0] RX_TID_LO = 16'h0001;
	localparam logic [15:0] RX_FUNC = 16'h0007;
	localparam logic [15:0] RX_LEN_SKEW = 16'h0005;
	// Confirmation causes
	localparam logic [1:0] CAUSE_RESP = 2'h0;
	localparam logic [1:0] CAUSE_TIMEOUT = 2'h1;
	localparam logic [1:0] CAUSE_SENDERR = 2'h2;
	localparam logic [1:0] CAUSE_FORMAT = 2'h3;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_HDR = 2'b01,
		TX_PDU = 2'b10
	} txState_t;
endpackage

// File: tb.sv
// Self-checking testbench for the request client framer
`timescale 1ns/100ps
module tb;
	localparam int TICKS = 128;
	localparam int TOUT = 5;
	logic clk_sys, rst_n, demValid, demReady, demDirect, pduValid, pduReady, txValid, txLast, txReady;
	logic sendErr, rxValid, rxLast, rxReady, cnfValid, cnfPositive, cnfException, cnfRemoteUnit, cnfDataValid;
	logic [31:0] demIp, txIp;
	logic [7:0] demUnit, demFunc, demLen, pduData, txData, rxData, cnfFunc, cnfUnit, cnfData;
	logic [15:0] txTid, sendErrTid, cnfTid, cTid;
	logic [1:0] cnfCause, cCause;
	logic [7:0] cFunc, cUnit, cData;
	logic cPos, cExc, cRem;
	int badCount = 0;
	int numChecks = 0;
	int cnfCount = 0;
	int dataCount = 0;
	tcp_request_client_framer #(.TICK_CYCLES(TICKS), .RESP_TIMEOUT_MS(16'(TOUT))) u_tcp_request_client_framer (
		.clk_sys, .rst_n, .demValid, .demReady, .demIp, .demDirect, .demUnit, .demFunc, .demLen,
		.pduValid, .pduData, .pduReady, .txValid, .txData, .txLast, .txIp, .txTid, .txReady,
		.sendErr, .sendErrTid, .rxValid, .rxData, .rxLast, .rxReady, .cnfValid, .cnfPositive,
		.cnfException, .cnfCause, .cnfTid, .cnfFunc, .cnfUnit, .cnfRemoteUnit, .cnfDataValid, .cnfData);
	tcp_side u_tcp_side (.clk_sys, .txValid, .txData, .txLast, .txIp, .txTid, .txReady,
		.sendErr, .sendErrTid, .rxValid, .rxData, .rxLast, .rxReady);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (cnfValid === 1'b1) begin
			cnfCount++;
			{cPos, cExc, cCause, cTid, cFunc, cUnit, cRem} =
				{cnfPositive, cnfException, cnfCause, cnfTid, cnfFunc, cnfUnit, cnfRemoteUnit};
		end
		if (cnfDataValid === 1'b1) begin
			dataCount++;
			cData = cnfData;
		end
	end
	task automatic giveVerdict();
		$display("Checks %0d, mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic stuck();
		badCount++;
		$display("MISMATCH at %0t: wait ran out", $time);
		giveVerdict();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic take(input logic pdu);
		int k;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while ((pdu ? pduReady : demReady) !== 1'b1 && k < 100);
		if ((pdu ? pduReady : demReady) !== 1'b1) stuck();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic do_demand(input logic dir, input logic [7:0] unit, func, len, output logic [15:0] tid);
		int n;
		int k;
		n = u_tcp_side.frmCount;
		{demIp, demDirect, demUnit, demFunc, demLen} = {32'h0A000100 + 32'(len), dir, unit, func, len};
		demValid = 1'b1;
		take(1'b0);
		demValid = 1'b0;
		for (int i = 0; i < len; i++) begin
			pduValid = 1'b1;
			pduData = 8'h40 + 8'(i);
			take(1'b1);
		end
		pduValid = 1'b0;
		for (k = 0; k < 80 && u_tcp_side.frmCount == n; k++) begin
			@(posedge clk_sys);
			#1;
		end
		if (u_tcp_side.frmCount == n) stuck();
		tid = {u_tcp_side.frm[0], u_tcp_side.frm[1]};
		check(u_tcp_side.frmTid, tid);
		check({u_tcp_side.frm[2], u_tcp_side.frm[3]}, 32'h0);
		check({u_tcp_side.frm[4], u_tcp_side.frm[5]}, 32'h2 + 32'(len));
		check(u_tcp_side.frm[6], dir ? 8'hFF : unit);
		check(u_tcp_side.frm[7], func);
		for (int i = 0; i < len; i++) check(u_tcp_side.frm[8 + i], 8'h40 + 8'(i));
		check(u_tcp_side.frmLen, 8 + len);
		check(u_tcp_side.frmIp, demIp);
	endtask
	task automatic respond(input logic [15:0] tid, pid, input logic [7:0] unit, func, input int nd);
		logic [7:0] b [$];
		b = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'(2 + nd), unit, func};
		for (int i = 0; i < nd; i++) b.push_back(8'hA0 + 8'(i));
		u_tcp_side.send_frame(b);
	endtask
	task automatic wait_cnf(input int lim, output int k);
		int n;
		n = cnfCount;
		for (k = 0; k < lim && cnfCount == n; k++) begin
			@(posedge clk_sys);
			#1;
		end
		if (cnfCount == n) stuck();
	endtask
	task automatic expect_cnf(input int lim, input logic pos, exc, input logic [1:0] cause);
		int k;
		wait_cnf(lim, k);
		check(cPos, pos);
		check(cExc, exc);
		check(cCause, cause);
	endtask
	task automatic no_cnf(input int lim);
		int n;
		n = cnfCount;
		repeat (lim) @(posedge clk_sys);
		#1;
		check(cnfCount, n);
	endtask
	task automatic s_positive();
		logic [15:0] tid;
		int d;
		do_demand(1'b1, 8'h07, 8'h03, 8'h04, tid);
		d = dataCount;
		respond(tid, 16'h0000, 8'hFF, 8'h03, 2);
		expect_cnf(20, 1'b1, 1'b0, client_framer_pkg::CAUSE_RESP);
		check(cTid, tid);
		check(cRem, 1'b0);
		check(dataCount - d, 2);
		check(cData, 8'hA1);
	endtask
	task automatic s_exception();
		logic [15:0] tid;
		do_demand(1'b0, 8'h05, 8'h06, 8'h00, tid);
		respond(tid, 16'h0000, 8'h05, 8'h86, 1);
		expect_cnf(20, 1'b1, 1'b1, client_framer_pkg::CAUSE_RESP);
		check(cFunc, 8'h86);
		check({cRem, cUnit}, 9'h105);
	endtask
	task automatic s_reject();
		logic [15:0] tid;
		do_demand(1'b0, 8'h00, 8'h10, 8'h01, tid);
		respond(tid + 16'h0010, 16'h0000, 8'hFF, 8'h10, 0);
		no_cnf(30);
		respond(tid, 16'h0000, 8'hFF, 8'h11, 0);
		expect_cnf(20, 1'b0, 1'b0, client_framer_pkg::CAUSE_FORMAT);
		do_demand(1'b1, 8'h00, 8'h10, 8'h00, tid);
		respond(tid, 16'h0001, 8'hFF, 8'h10, 0);
		expect_cnf(20, 1'b0, 1'b0, client_framer_pkg::CAUSE_FORMAT);
	endtask
	task automatic s_senderr_timeout();
		logic [15:0] tid;
		int k;
		do_demand(1'b1, 8'h00, 8'h03, 8'h00, tid);
		u_tcp_side.report_error(tid);
		expect_cnf(20, 1'b0, 1'b0, client_framer_pkg::CAUSE_SENDERR);
		check(cTid, tid);
		do_demand(1'b1, 8'h00, 8'h03, 8'h00, tid);
		wait_cnf(TICKS * TOUT + 40, k);
		check(k >= TICKS * (TOUT - 1) - 20, 1'b1);
		check({cPos, cCause}, {1'b0, client_framer_pkg::CAUSE_TIMEOUT});
		respond(tid, 16'h0000, 8'hFF, 8'h03, 0);
		no_cnf(30);
	endtask
	task automatic s_fill();
		logic [15:0] tids [0:15];
		u_tcp_side.stall = 1'b1;
		for (int i = 0; i < 16; i++) do_demand(1'b1, 8'h00, 8'h04, 8'h00, tids[i]);
		u_tcp_side.stall = 1'b0;
		@(negedge clk_sys);
		check(demReady, 1'b0);
		for (int i = 0; i < 16; i++)
			for (int j = i + 1; j < 16; j++) check(tids[i] == tids[j], 1'b0);
		for (int i = 0; i < 16; i++) expect_cnf(TICKS * TOUT + 40, 1'b0, 1'b0, 2'h1);
		@(negedge clk_sys);
		check(demReady, 1'b1);
		@(posedge clk_sys);
		#1;
	endtask
	initial begin
		{demValid, demDirect, pduValid, demIp, demUnit, demFunc, demLen, pduData} = '0;
		rst_n = 1'b0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		s_positive();
		s_exception();
		s_reject();
		s_senderr_timeout();
		s_fill();
		giveVerdict();
	end
endmodule

// File: tcp_request_client_framer.sv
// Client transaction engine: builds request frames, matches responses, handles timeouts
// Behaviour
// RULE1: react to demand, response and timeout events
// RULE2: allocate a context per user demand
// RULE3: prefix header before function code and data
// RULE4: header order tid, protocol, length, unit
// RULE5: pass destination IP with each frame
// RULE6: no two pending transactions share identifier
// RULE7: identifier from counter or table index
// RULE8: up to sixteen outstanding, build parameter
// RULE9: gateway routes by unit identifier
// RULE10: direct server gets unit 0xFF
// RULE11: direct server also accepts unit zero
// RULE12: drop responses matching no pending transaction
// RULE13: matched response yields positive or negative confirmation
// RULE14: check protocol zero, length sizes response
// RULE15: unit 0xFF ignored, else remote reported
// RULE16: same function code gives positive confirmation
// RULE17: code plus 80h is positive exception
// RULE18: other code or bad format negative
// RULE19: on timeout resend or negatively confirm
// RULE20: TCP side may report send error
// RULE21: function code plus data at most 256
// RULE22: fields MSB first, length counts unit onward
// RULE23: free context after any confirmation
`timescale 1ns/100ps
module tcp_request_client_framer #(
	parameter int MAX_CLIENT_TRANSACTIONS = client_framer_pkg::MAX_TRANS,
	parameter int TICK_CYCLES = client_framer_pkg::TICK_CYCLES,
	parameter logic [15:0] RESP_TIMEOUT_MS = client_framer_pkg::RESP_TIMEOUT_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// User demand
	input wire logic demValid,
	output logic demReady,
	input wire logic [31:0] demIp,
	input wire logic demDirect,
	input wire logic [7:0] demUnit,
	input wire logic [7:0] demFunc,
	input wire logic [7:0] demLen,
	// User request data after the function code
	input wire logic pduValid,
	input wire logic [7:0] pduData,
	output logic pduReady,
	// Frame toward TCP management
	output logic txValid,
	output logic [7:0] txData,
	output logic txLast,
	output logic [31:0] txIp,
	output logic [15:0] txTid,
	input wire logic txReady,
	// Send error from TCP management
	input wire logic sendErr,
	input wire logic [15:0] sendErrTid,
	// Frame from TCP management
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxLast,
	output logic rxReady,
	// Confirmation toward user
	output logic cnfValid,
	output logic cnfPositive,
	output logic cnfException,
	output logic [1:0] cnfCause,
	output logic [15:0] cnfTid,
	output logic [7:0] cnfFunc,
	output logic [7:0] cnfUnit,
	output logic cnfRemoteUnit,
	output logic cnfDataValid,
	output logic [7:0] cnfData
);
	localparam int SW = client_framer_pkg::SLOT_W;
	localparam int NT = MAX_CLIENT_TRANSACTIONS;

	logic [1:0] rstPipe_r;
	logic rstSys_n;
	logic tick;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_r <= 2'b00;
		end else begin
			rstPipe_r <= {rstPipe_r[0], 1'b1};
		end
	end
	assign rstSys_n = rstPipe_r[1];

	tick_divider #(.CYCLES(TICK_CYCLES)) msTick (
		.clk_sys(clk_sys),
		.rstSys_n(rstSys_n),
		.tick(tick)
	);

	// Transaction table
	logic [NT-1:0] busy_r, busy_nxt, expired_r, expired_nxt, failed_r, failed_nxt;
	logic [15:0] tidTab_r [NT], tidTab_nxt [NT], age_r [NT], age_nxt [NT];
	logic [7:0] funcTab_r [NT], funcTab_nxt [NT];
	logic anyFree, lookupHit, errHit;
	logic [SW-1:0] freeSlot, lookupSlot, errSlot, cnfSlot_r, cnfSlot_nxt;

	// Transmit state
	client_framer_pkg::txState_t txState_r, txState_nxt;
	logic [2:0] txIdx_r, txIdx_nxt;
	logic [7:0] txUnit_r, txUnit_nxt, txFunc_r, txFunc_nxt, txLen_r, txLen_nxt;
	logic [7:0] txData_r, txData_nxt, hdrByte;
	logic [15:0] txTid_r, txTid_nxt, lenField;
	logic [31:0] txIp_r, txIp_nxt;
	localparam int SEQ_WL = client_framer_pkg::SEQ_W;
	logic [SEQ_WL-1:0] seq_r, seq_nxt;
	logic txValid_r, txValid_nxt, txLast_r, txLast_nxt, loadOk, accept;

	// Receive state
	logic [15:0] rxCnt_r, rxCnt_nxt, rxPid_r, rxPid_nxt, rxLen_r, rxLen_nxt;
	logic [7:0] rxTidHi_r, rxTidHi_nxt, rxUnit_r, rxUnit_nxt, rxFunc_r, rxFunc_nxt, funcNow;
	logic [SW-1:0] rxSlot_r, rxSlot_nxt, finSlot;
	logic rxHit_r, rxHit_nxt, hitNow, rxFinish, rxPos, rxExc, fmtOk;
	logic cnfDataValid_r, cnfDataValid_nxt;
	logic [7:0] cnfData_r, cnfData_nxt;

	// Confirmation registers
	logic cnfValid_r, cnfValid_nxt, cnfPos_r, cnfPos_nxt, cnfExc_r, cnfExc_nxt, cnfRemote_r, cnfRemote_nxt;
	logic [1:0] cnfCause_r, cnfCause_nxt;
	logic [15:0] cnfTid_r, cnfTid_nxt;
	logic [7:0] cnfFunc_r, cnfFunc_nxt, cnfUnit_r, cnfUnit_nxt;

	// Lowest free slot and table lookups
	always_comb begin
		anyFree = 1'b0;
		freeSlot = '0;
		lookupHit = 1'b0;
		lookupSlot = '0;
		errHit = 1'b0;
		errSlot = '0;
		for (int i = NT - 1; i >= 0; i--) begin
			if (!busy_r[i]) begin // see RULE8
				anyFree = 1'b1;
				freeSlot = SW'(i);
			end
			if (busy_r[i] && tidTab_r[i] == {rxTidHi_r, rxData}) begin // see RULE12
				lookupHit = 1'b1;
				lookupSlot = SW'(i);
			end
			if (busy_r[i] && tidTab_r[i] == sendErrTid) begin // see RULE20
				errHit = 1'b1;
				errSlot = SW'(i);
			end
		end
	end

	// Transmit path
	assign loadOk = !txValid_r || txReady;
	assign demReady = (txState_r == client_framer_pkg::TX_IDLE) && anyFree && !txValid_r;
	assign pduReady = (txState_r == client_framer_pkg::TX_PDU) && loadOk;
	assign accept = demValid && demReady;
	assign lenField = client_framer_pkg::LEN_FIXED + 16'(txLen_r); // see RULE22

	always_comb begin
		unique case (txIdx_r) // see RULE4
			client_framer_pkg::HDR_TID_HI: hdrByte = txTid_r[15:8];
			client_framer_pkg::HDR_TID_LO: hdrByte = txTid_r[7:0];
			client_framer_pkg::HDR_PID_HI: hdrByte = client_framer_pkg::PROTO_ID[15:8];
			client_framer_pkg::HDR_PID_LO: hdrByte = client_framer_pkg::PROTO_ID[7:0];
			client_framer_pkg::HDR_LEN_HI: hdrByte = lenField[15:8];
			client_framer_pkg::HDR_LEN_LO: hdrByte = lenField[7:0];
			client_framer_pkg::HDR_UNIT: hdrByte = txUnit_r;
			client_framer_pkg::HDR_FUNC: hdrByte = txFunc_r;
		endcase
	end

	always_comb begin
		txState_nxt = txState_r;
		txIdx_nxt = txIdx_r;
		txUnit_nxt = txUnit_r;
		txFunc_nxt = txFunc_r;
		txLen_nxt = txLen_r;
		txTid_nxt = txTid_r;
		txIp_nxt = txIp_r;
		seq_nxt = seq_r;
		txData_nxt = txData_r;
		txLast_nxt = txLast_r;
		txValid_nxt = txValid_r && !txReady;
		unique case (txState_r)
			client_framer_pkg::TX_IDLE: begin
				if (accept) begin
					txState_nxt = client_framer_pkg::TX_HDR;
					txIdx_nxt = client_framer_pkg::HDR_TID_HI;
					txIp_nxt = demIp; // see RULE5
					txTid_nxt = {seq_r, freeSlot}; // see RULE7
					seq_nxt = seq_r + 1'b1;
					txUnit_nxt = demDirect ? client_framer_pkg::UNIT_NONSIG : demUnit; // see RULE10
					txFunc_nxt = demFunc;
					txLen_nxt = demLen; // see RULE21
				end
			end
			client_framer_pkg::TX_HDR: begin
				if (loadOk) begin // see RULE3
					txValid_nxt = 1'b1;
					txData_nxt = hdrByte;
					txIdx_nxt = txIdx_r + 1'b1;
					txLast_nxt = (txIdx_r == client_framer_pkg::HDR_FUNC) && (txLen_r == 8'h00);
					if (txIdx_r == client_framer_pkg::HDR_FUNC) begin
						txState_nxt = (txLen_r == 8'h00) ? client_framer_pkg::TX_IDLE : client_framer_pkg::TX_PDU;
					end
				end
			end
			client_framer_pkg::TX_PDU: begin
				if (pduValid && pduReady) begin
					txValid_nxt = 1'b1;
					txData_nxt = pduData;
					txLast_nxt = (txLen_r == 8'h01);
					txLen_nxt = txLen_r - 1'b1;
					if (txLen_r == 8'h01) begin
						txState_nxt = client_framer_pkg::TX_IDLE;
					end
				end
			end
			default: txState_nxt = client_framer_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstSys_n) begin
		if (!rstSys_n) begin
			txState_r <= client_framer_pkg::TX_IDLE;
			txIdx_r <= 3'h0;
			txUnit_r <= 8'h00;
			txFunc_r <= 8'h00;
			txLen_r <= 8'h00;
			txTid_r <= 16'h0000;
			txIp_r <= 32'h0000_0000;
			seq_r <= '0;
			txData_r <= 8'h00;
			txLast_r <= 1'b0;
			txValid_r <= 1'b0;
		end else begin
			txState_r <= txState_nxt;
			txIdx_r <= txIdx_nxt;
			txUnit_r <= txUnit_nxt;
			txFunc_r <= txFunc_nxt;
			txLen_r <= txLen_nxt;
			txTid_r <= txTid_nxt;
			txIp_r <= txIp_nxt;
			seq_r <= seq_nxt;
			txData_r <= txData_nxt;
			txLast_r <= txLast_nxt;
			txValid_r <= txValid_nxt;
		end
	end

	// Receive parser; never back-pressures TCP management
	assign rxReady = 1'b1;
	assign hitNow = (rxCnt_r == client_framer_pkg::RX_TID_LO) ? lookupHit : rxHit_r;
	assign finSlot = (rxCnt_r == client_framer_pkg::RX_TID_LO) ? lookupSlot : rxSlot_r;
	assign funcNow = (rxCnt_r == client_framer_pkg::RX_FUNC) ? rxData : rxFunc_r;
	assign fmtOk = (rxPid_r == client_framer_pkg::PROTO_ID) && (rxCnt_r >= client_framer_pkg::RX_FUNC)
		&& (rxLen_r == rxCnt_r - client_framer_pkg::RX_LEN_SKEW); // see RULE14

	always_comb begin
		rxCnt_nxt = rxCnt_r;
		rxTidHi_nxt = rxTidHi_r;
		rxPid_nxt = rxPid_r;
		rxLen_nxt = rxLen_r;
		rxUnit_nxt = rxUnit_r;
		rxFunc_nxt = rxFunc_r;
		rxHit_nxt = rxHit_r;
		rxSlot_nxt = rxSlot_r;
		cnfDataValid_nxt = 1'b0;
		cnfData_nxt = cnfData_r;
		rxFinish = 1'b0;
		rxPos = 1'b0;
		rxExc = 1'b0;
		if (rxValid) begin
			rxCnt_nxt = (rxCnt_r == 16'hFFFF) ? rxCnt_r : rxCnt_r + 16'h0001;
			unique case (rxCnt_r)
				16'h0000: rxTidHi_nxt = rxData;
				16'h0001: begin
					rxHit_nxt = lookupHit;
					rxSlot_nxt = lookupSlot;
				end
				16'h0002: rxPid_nxt = {rxData, rxPid_r[7:0]};
				16'h0003: rxPid_nxt = {rxPid_r[15:8], rxData};
				16'h0004: rxLen_nxt = {rxData, rxLen_r[7:0]};
				16'h0005: rxLen_nxt = {rxLen_r[15:8], rxData};
				16'h0006: rxUnit_nxt = rxData;
				16'h0007: rxFunc_nxt = rxData;
				default: begin
					cnfDataValid_nxt = rxHit_r;
					cnfData_nxt = rxData;
				end
			endcase
			if (rxLast) begin
				rxCnt_nxt = 16'h0000;
				rxHit_nxt = 1'b0;
				rxFinish = hitNow && busy_r[finSlot]; // see RULE12
				rxPos = fmtOk && (funcNow == funcTab_r[finSlot]); // see RULE16
				rxExc = fmtOk && (funcNow == funcTab_r[finSlot] + client_framer_pkg::EXC_OFFSET); // see RULE17
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstSys_n) begin
		if (!rstSys_n) begin
			rxCnt_r <= 16'h0000;
			rxTidHi_r <= 8'h00;
			rxPid_r <= 16'h0000;
			rxLen_r <= 16'h0000;
			rxUnit_r <= 8'h00;
			rxFunc_r <= 8'h00;
			rxHit_r <= 1'b0;
			rxSlot_r <= '0;
			cnfDataValid_r <= 1'b0;
			cnfData_r <= 8'h00;
		end else begin
			rxCnt_r <= rxCnt_nxt;
			rxTidHi_r <= rxTidHi_nxt;
			rxPid_r <= rxPid_nxt;
			rxLen_r <= rxLen_nxt;
			rxUnit_r <= rxUnit_nxt;
			rxFunc_r <= rxFunc_nxt;
			rxHit_r <= rxHit_nxt;
			rxSlot_r <= rxSlot_nxt;
			cnfDataValid_r <= cnfDataValid_nxt;
			cnfData_r <= cnfData_nxt;
		end
	end

	// Table upkeep and confirmations; response wins, timeouts and send errors wait a cycle
	always_comb begin
		logic pick;
		pick = 1'b0;
		busy_nxt = busy_r;
		expired_nxt = expired_r;
		failed_nxt = failed_r;
		tidTab_nxt = tidTab_r;
		funcTab_nxt = funcTab_r;
		age_nxt = age_r;
		cnfValid_nxt = 1'b0;
		cnfPos_nxt = cnfPos_r;
		cnfExc_nxt = cnfExc_r;
		cnfCause_nxt = cnfCause_r;
		cnfTid_nxt = cnfTid_r;
		cnfFunc_nxt = cnfFunc_r;
		cnfUnit_nxt = cnfUnit_r;
		cnfRemote_nxt = cnfRemote_r;
		cnfSlot_nxt = cnfSlot_r;
		for (int i = 0; i < NT; i++) begin
			if (busy_r[i] && tick && age_r[i] != RESP_TIMEOUT_MS) begin
				age_nxt[i] = age_r[i] + 16'h0001;
			end
			if (busy_r[i] && age_r[i] == RESP_TIMEOUT_MS) begin
				expired_nxt[i] = 1'b1; // see RULE1
			end
		end
		if (sendErr && errHit) begin
			failed_nxt[errSlot] = 1'b1; // see RULE20
		end
		if (rxFinish) begin // see RULE13
			cnfValid_nxt = 1'b1;
			cnfSlot_nxt = finSlot;
			cnfPos_nxt = rxPos || rxExc;
			cnfExc_nxt = rxExc;
			cnfCause_nxt = (rxPos || rxExc) ? client_framer_pkg::CAUSE_RESP : client_framer_pkg::CAUSE_FORMAT; // see RULE18
			cnfTid_nxt = tidTab_r[finSlot];
			cnfFunc_nxt = funcNow;
			cnfUnit_nxt = rxUnit_r;
			cnfRemote_nxt = (rxUnit_r != client_framer_pkg::UNIT_NONSIG); // see RULE15
			busy_nxt[finSlot] = 1'b0; // see RULE23
		end else begin
			for (int i = 0; i < NT; i++) begin
				if (!pick && busy_r[i] && (expired_r[i] || failed_r[i])) begin // see RULE19
					pick = 1'b1;
					cnfValid_nxt = 1'b1;
					cnfSlot_nxt = SW'(i);
					cnfPos_nxt = 1'b0;
					cnfExc_nxt = 1'b0;
					cnfCause_nxt = failed_r[i] ? client_framer_pkg::CAUSE_SENDERR : client_framer_pkg::CAUSE_TIMEOUT;
					cnfTid_nxt = tidTab_r[i];
					cnfFunc_nxt = funcTab_r[i];
					cnfUnit_nxt = client_framer_pkg::UNIT_NONSIG;
					cnfRemote_nxt = 1'b0;
					busy_nxt[i] = 1'b0; // see RULE23
				end
			end
		end
		if (accept) begin // see RULE2
			busy_nxt[freeSlot] = 1'b1; // see RULE6
			tidTab_nxt[freeSlot] = {seq_r, freeSlot};
			funcTab_nxt[freeSlot] = demFunc;
			age_nxt[freeSlot] = 16'h0000;
			expired_nxt[freeSlot] = 1'b0;
			failed_nxt[freeSlot] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSys_n) begin
		if (!rstSys_n) begin
			busy_r <= '0;
			expired_r <= '0;
			failed_r <= '0;
			for (int i = 0; i < NT; i++) begin
				tidTab_r[i] <= 16'h0000;
				funcTab_r[i] <= 8'h00;
				age_r[i] <= 16'h0000;
			end
			cnfValid_r <= 1'b0;
			cnfPos_r <= 1'b0;
			cnfExc_r <= 1'b0;
			cnfCause_r <= 2'h0;
			cnfTid_r <= 16'h0000;
			cnfFunc_r <= 8'h00;
			cnfUnit_r <= 8'h00;
			cnfRemote_r <= 1'b0;
			cnfSlot_r <= '0;
		end else begin
			busy_r <= busy_nxt;
			expired_r <= expired_nxt;
			failed_r <= failed_nxt;
			tidTab_r <= tidTab_nxt;
			funcTab_r <= funcTab_nxt;
			age_r <= age_nxt;
			cnfValid_r <= cnfValid_nxt;
			cnfPos_r <= cnfPos_nxt;
			cnfExc_r <= cnfExc_nxt;
			cnfCause_r <= cnfCause_nxt;
			cnfTid_r <= cnfTid_nxt;
			cnfFunc_r <= cnfFunc_nxt;
			cnfUnit_r <= cnfUnit_nxt;
			cnfRemote_r <= cnfRemote_nxt;
			cnfSlot_r <= cnfSlot_nxt;
		end
	end

	assign txValid = txValid_r;
	assign txData = txData_r;
	assign txLast = txLast_r;
	assign txIp = txIp_r;
	assign txTid = txTid_r;
	assign cnfValid = cnfValid_r;
	assign cnfPositive = cnfPos_r;
	assign cnfException = cnfExc_r;
	assign cnfCause = cnfCause_r;
	assign cnfTid = cnfTid_r;
	assign cnfFunc = cnfFunc_r;
	assign cnfUnit = cnfUnit_r;
	assign cnfRemoteUnit = cnfRemote_r;
	assign cnfDataValid = cnfDataValid_r;
	assign cnfData = cnfData_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstSys_n);

	alloc_free_slot_a: assert property (accept |-> !busy_r[freeSlot] ##1 busy_r[$past(freeSlot)]) // see RULE6
		else $error("allocated slot was already pending");
	tid_assign_a: assert property (accept |=> txTid_r == {$past(seq_r), $past(freeSlot)}) // see RULE7
		else $error("transaction identifier not formed from counter and slot");
	proto_bytes_a: assert property (txValid_r && txState_r == client_framer_pkg::TX_HDR
		&& (txIdx_r == 3'h3 || txIdx_r == 3'h4) |-> txData_r == 8'h00) // see RULE4
		else $error("protocol identifier byte not zero");
	direct_unit_a: assert property (accept && demDirect |=> ##7 txUnit_r == 8'hFF) // see RULE10
		else $error("direct server not addressed with unit FF");
	frame_ip_a: assert property (txValid_r |-> $stable(txIp_r) && $stable(txTid_r)) // see RULE5
		else $error("destination changed while frame in flight");
	drop_silent_a: assert property (rxValid && rxLast && !hitNow |=> !(cnfValid_r && cnfCause_r == 2'h0)) // see RULE12
		else $error("unmatched response confirmed");
	exc_positive_a: assert property (cnfValid_r && cnfExc_r |-> cnfPos_r && cnfCause_r == 2'h0) // see RULE17
		else $error("exception response not positive");
	neg_cause_a: assert property (cnfValid_r && !cnfPos_r |-> cnfCause_r != 2'h0) // see RULE18
		else $error("negative confirmation without error cause");
	slot_freed_a: assert property (cnfValid_r |-> !busy_r[cnfSlot_r]) // see RULE23
		else $error("context not freed after confirmation");
	timeout_fire_a: assert property (busy_r[0] && age_r[0] == RESP_TIMEOUT_MS && !rxFinish
		|=> ##[0:2] (cnfValid_r && cnfSlot_r == 4'h0)) // see RULE19
		else $error("expired transaction not confirmed");
	last_len_a: assert property (txValid_r && txLast_r |-> txState_r == client_framer_pkg::TX_IDLE) // see RULE3
		else $error("frame ended before all data sent");

	positive_cov_c: cover property (cnfValid_r && cnfPos_r && !cnfExc_r);
	exception_cov_c: cover property (cnfValid_r && cnfExc_r);
	timeout_cov_c: cover property (cnfValid_r && cnfCause_r == 2'h1);
	senderr_cov_c: cover property (cnfValid_r && cnfCause_r == 2'h2);
endmodule

// File: tcp_side.sv
// Behavioural TCP management side: takes request frames, returns responses and send errors
`timescale 1ns/100ps
module tcp_side (
	// Clock
	input wire logic clk_sys,
	// Request frame
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txLast,
	input wire logic [31:0] txIp,
	input wire logic [15:0] txTid,
	output logic txReady,
	// Send error
	output logic sendErr,
	output logic [15:0] sendErrTid,
	// Response frame
	output logic rxValid,
	output logic [7:0] rxData,
	output logic rxLast,
	input wire logic rxReady
);
	logic [7:0] frm [0:299];
	logic [31:0] frmIp;
	logic [15:0] frmTid;
	logic stall = 1'b0;
	int frmIdx = 0;
	int frmLen = 0;
	int frmCount = 0;
	initial begin
		{txReady, sendErr, rxValid, rxLast} = '0;
		sendErrTid = 16'h0000;
		rxData = 8'h00;
	end
	// Stalling halves the byte rate to exercise the hold of txData
	always @(posedge clk_sys) begin
		txReady <= stall ? ~txReady : 1'b1;
		if (txValid && txReady) begin
			frm[frmIdx] <= txData;
			frmIdx <= txLast ? 0 : frmIdx + 1;
			if (txLast) begin
				frmLen <= frmIdx + 1;
				frmIp <= txIp;
				frmTid <= txTid;
				frmCount <= frmCount + 1;
			end
		end
	end
	task automatic send_frame(input logic [7:0] b [$]);
		for (int i = 0; i < b.size(); i++) begin
			@(posedge clk_sys);
			#1;
			rxValid = 1'b1;
			rxData = b[i];
			rxLast = (i == b.size() - 1);
		end
		@(posedge clk_sys);
		#1;
		{rxValid, rxLast} = '0;
		// Released line shows no stale byte
		rxData = ~rxData;
	endtask
	task automatic report_error(input logic [15:0] tid);
		@(posedge clk_sys);
		#1;
		sendErr = 1'b1;
		sendErrTid = tid;
		@(posedge clk_sys);
		#1;
		sendErr = 1'b0;
		sendErrTid = ~tid;
	endtask
endmodule

// File: tick_divider.sv
// Divider that yields a one-cycle enable every CYCLES clocks
`timescale 1ns/100ps
module tick_divider #(
	parameter int CYCLES = 125000
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstSys_n,
	// Enable out
	output logic tick
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;

	always_comb begin
		tick = (cnt_r == 32'(CYCLES - 1));
		cnt_nxt = tick ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge rstSys_n) begin
		if (!rstSys_n) begin
			cnt_r <= 32'h0000_0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule
